// File: pkg/fps_pkg.sv
// -----------------------------------------------------------------------
// Functional notes
// - Unlock needs key 55h then AAh, two consecutive key writes.
// - Processor stays stalled from operation start until it finishes.
// - Start bit 15 launches self-timed operation; hardware clears it.
// - Permit bit 14 clear inhibits every program and erase.
// - Error bit 13 flags improper start; cleared by a proper start.
// - Erase-select bit 6 picks erase or program for the next start.
// - Codes 1001xx, 0101xx, 0011xx erase all, config, general regions.
// - Codes 1010xx and 1001xx only honoured in external serial mode.
// - Codes 011000, 011001, 011010 handle one, two or four rows.
// - Unlisted codes cause no operation at start.
// - Row erases take their rows from the table pointer address.
// - Table writes land in holding latches, committed only on program.
// - Row blocks align to their own size from program memory start.
// -----------------------------------------------------------------------
package fps_pkg;

   // --------------------------------------------------------------------
   // Register map
   // --------------------------------------------------------------------
   localparam int         ADDR_W      = 4;
   localparam int         DATA_W      = 16;
   localparam logic [3:0] CTRL_OFS    = 4'h0;
   localparam logic [3:0] KEY_OFS     = 4'h1;
   localparam logic [3:0] PAGE_OFS    = 4'h2;
   localparam logic [3:0] PTR_OFS     = 4'h3;
   localparam logic [3:0] LAT_LO_OFS  = 4'h4;
   localparam logic [3:0] LAT_HI_OFS  = 4'h5;
   localparam int         WR_BIT      = 15;
   localparam int         PERMIT_BIT  = 14;
   localparam int         ERR_BIT     = 13;
   localparam int         PROG_ONLY_BIT = 12;
   localparam int         ERASE_BIT   = 6;
   localparam int         CODE_W      = 6;
   localparam int         CFG_PAGE_BIT = 7;
   localparam logic [7:0]  KEY_FIRST  = 8'h55;
   localparam logic [7:0]  KEY_SECOND = 8'hAA;
   localparam logic [7:0]  PAGE_RESET = 8'h00;
   localparam logic [15:0] PTR_RESET  = 16'h0000;
   localparam logic [15:0] PTR_STEP   = 16'h0002;

   // --------------------------------------------------------------------
   // Command codes and row geometry
   // --------------------------------------------------------------------
   localparam logic [3:0] CODE_BOOT  = 4'hA;
   localparam logic [3:0] CODE_ALL   = 4'h9;
   localparam logic [3:0] CODE_CFG   = 4'h5;
   localparam logic [3:0] CODE_GEN   = 4'h3;
   localparam logic [5:0] CODE_ROW1  = 6'h18;
   localparam logic [5:0] CODE_ROW2  = 6'h19;
   localparam logic [5:0] CODE_ROW4  = 6'h1A;
   localparam int         LAT_IDX_W  = 5;
   localparam int         WORD_W     = 24;
   localparam int         ADDR_FULL_W = 24;
   localparam logic [23:0] MASK_ROW1 = 24'h00003F;
   localparam logic [23:0] MASK_ROW2 = 24'h00007F;
   localparam logic [23:0] MASK_ROW4 = 24'h0000FF;

   // --------------------------------------------------------------------
   // Timing, 25 MHz clock; least times round up
   // --------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int PROG_TIME_NS  = 2000;
   localparam int ERASE_TIME_NS = 4000;
   localparam int TIME_W        = 8;
   localparam logic [TIME_W-1:0] PROG_CYC = TIME_W'(
      (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TIME_W-1:0] ERASE_CYC = TIME_W'(
      (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // --------------------------------------------------------------------
   // Types
   // --------------------------------------------------------------------
   typedef enum logic [2:0] {
      REG_NONE, REG_ROWS, REG_GENERAL, REG_CONFIG, REG_ALL, REG_BOOT
   } fps_region_t;

   typedef struct packed {
      logic        valid;
      logic        erase;
      fps_region_t region;
      logic [2:0]  rows;
   } fps_op_t;

   typedef struct packed {
      logic                   wr_word;
      logic                   erase;
      fps_region_t            region;
      logic [2:0]             rows;
      logic [ADDR_FULL_W-1:0] addr;
      logic [WORD_W-1:0]      data;
   } fps_flash_req_t;

   typedef struct packed {
      logic              wr;
      logic              permit;
      logic              err;
      logic              prog_only;
      logic              erase;
      logic [CODE_W-1:0] code;
   } fps_ctrl_t;

   function automatic fps_op_t fps_decode(input logic [5:0] code,
                                          input logic       erase,
                                          input logic       ext_mode);
      fps_op_t op;
      op = '{valid: 1'b0, erase: erase, region: REG_NONE, rows: 3'h0};
      if (code == CODE_ROW1 || code == CODE_ROW2 || code == CODE_ROW4) begin
         op.valid  = 1'b1;
         op.region = REG_ROWS;
         op.rows   = (code == CODE_ROW1) ? 3'h1 :
                     (code == CODE_ROW2) ? 3'h2 : 3'h4;
      end else if (erase) begin
         op.valid = 1'b1;
         case (code[5:2])
            CODE_BOOT: op.region = REG_BOOT;
            CODE_ALL:  op.region = REG_ALL;
            CODE_CFG:  op.region = REG_CONFIG;
            CODE_GEN:  op.region = REG_GENERAL;
            default:   op.valid  = 1'b0;
         endcase
         if ((op.region == REG_BOOT || op.region == REG_ALL) && !ext_mode) begin
            op.valid = 1'b0;
         end
      end
      return op;
   endfunction

endpackage

// File: src/fps_latch_mem.sv
`timescale 1ns/10ps
module fps_latch_mem
   import fps_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 lo_we_in,
   input  wire logic                 hi_we_in,
   input  wire logic [LAT_IDX_W-1:0] wr_idx_in,
   input  wire logic [15:0]          wdata_in,
   input  wire logic [LAT_IDX_W-1:0] rd_idx_in,
   output logic      [WORD_W-1:0]    rdata_out
);
   import fps_pkg::*;

   // Holding latches; contents survive reset like a real latch array
   logic [WORD_W-1:0] mem [2**LAT_IDX_W];

   always_ff @(posedge sys_clk_in) begin
      if (lo_we_in) begin
         mem[wr_idx_in][15:0] <= wdata_in;
      end
      if (hi_we_in) begin
         mem[wr_idx_in][23:16] <= wdata_in[7:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      rdata_out <= mem[rd_idx_in];
   end

endmodule

// File: src/fps_op_timer.sv
`timescale 1ns/10ps
module fps_op_timer
   import fps_pkg::*;
(
   input  wire logic              sys_clk_in,
   input  wire logic              rstn_in,
   input  wire logic              load_in,
   input  wire logic [TIME_W-1:0] len_in,
   output logic                   done_out
);
   import fps_pkg::*;

   logic [TIME_W-1:0] cnt_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cnt_q <= '0;
      end else if (load_in) begin
         cnt_q <= len_in;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - TIME_W'(1);
      end
   end

   // One-cycle pulse as the count runs out
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= !load_in && (cnt_q == TIME_W'(1));
      end
   end

endmodule

// File: src/fps_sequencer.sv
`timescale 1ns/10ps
module fps_sequencer
   import fps_pkg::*;
(
   input  wire logic                    sys_clk_in,
   input  wire logic                    rstn_in,
   input  wire logic [fps_pkg::ADDR_W-1:0] reg_addr_in,
   input  wire logic [fps_pkg::DATA_W-1:0] reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   input  wire logic                    ext_prog_mode_in,
   output logic [fps_pkg::DATA_W-1:0]   reg_rdata_out,
   output logic                         cpu_stall_out,
   output fps_pkg::fps_flash_req_t      flash_req_out
);
   import fps_pkg::*;

   // --------------------------------------------------------------------
   // State and types
   // --------------------------------------------------------------------
   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_GOT55 = 2'b01,
      KEY_ARMED = 2'b11
   } fps_key_t;

   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_LOAD = 2'b01,
      OP_WAIT = 2'b11,
      OP_DONE = 2'b10
   } fps_opst_t;

   fps_key_t          key_q;
   fps_opst_t         op_state_q;
   fps_ctrl_t         ctrl_q;
   fps_op_t           op_q;
   logic [7:0]        page_q;
   logic [15:0]       ptr_q;
   logic [23:0]       op_addr_q;
   logic [7:0]        word_cnt_q;
   logic [7:0]        pipe_idx_q;
   logic              pipe_q;
   logic [WORD_W-1:0] lat_rdata;
   logic              tmr_done;

   function automatic logic [23:0] row_mask(input logic [2:0] rows);
      return (rows == 3'h4) ? MASK_ROW4 :
             (rows == 3'h2) ? MASK_ROW2 : MASK_ROW1;
   endfunction

   // --------------------------------------------------------------------
   // Decode of the current access
   // --------------------------------------------------------------------
   logic        ctrl_wr;
   logic        key_wr;
   logic        start_try;
   logic        start_ok;
   logic        start_bad;
   logic        op_done;
   logic        load_last;
   logic        tmr_load;
   logic [7:0]  total_words;
   logic [23:0] start_addr;
   fps_op_t     dec;

   assign ctrl_wr   = reg_wr_in && (reg_addr_in == CTRL_OFS);
   assign key_wr    = reg_wr_in && (reg_addr_in == KEY_OFS);
   // Code and select come from the same write, as a bit-set rewrites all
   assign dec       = fps_decode(reg_wdata_in[CODE_W-1:0],
                                 reg_wdata_in[ERASE_BIT],
                                 ext_prog_mode_in);
   assign start_try = ctrl_wr && reg_wdata_in[WR_BIT] && !ctrl_q.wr;
   assign start_bad = start_try &&
                      (key_q != KEY_ARMED ||
                       !reg_wdata_in[PERMIT_BIT]);
   // Unlisted or mode-locked codes: quietly nothing happens
   assign start_ok  = start_try && !start_bad && dec.valid;
   assign op_done   = (op_state_q == OP_DONE);
   assign total_words = {op_q.rows, 5'h00};
   assign load_last = (op_state_q == OP_LOAD) && pipe_q &&
                      (word_cnt_q == total_words);
   assign tmr_load  = (start_ok && dec.erase) || load_last;
   // Row blocks are taken from the table pointer, aligned down
   assign start_addr = (dec.region == REG_ROWS) ?
                       ({page_q, ptr_q} & ~row_mask(dec.rows)) :
                       24'h000000;

   // --------------------------------------------------------------------
   // Unlock key sequencer
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         key_q <= KEY_IDLE;
      end else if (reg_wr_in || reg_rd_in) begin
         case (key_q)
            KEY_IDLE: begin
               key_q <= (key_wr && reg_wdata_in[7:0] == KEY_FIRST) ?
                        KEY_GOT55 : KEY_IDLE;
            end
            KEY_GOT55: begin
               // Anything but the second key throws the unlock away
               key_q <= (key_wr && reg_wdata_in[7:0] == KEY_SECOND) ?
                        KEY_ARMED : KEY_IDLE;
            end
            KEY_ARMED: begin
               // Reads let a bit-set fetch the register; writes consume
               if (reg_wr_in) begin
                  key_q <= (key_wr && reg_wdata_in[7:0] == KEY_FIRST) ?
                           KEY_GOT55 : KEY_IDLE;
               end
            end
            default: key_q <= KEY_IDLE;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Control register
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         ctrl_q <= '0;
      end else if (ctrl_wr && !ctrl_q.wr) begin
         ctrl_q.permit    <= reg_wdata_in[PERMIT_BIT];
         ctrl_q.prog_only <= reg_wdata_in[PROG_ONLY_BIT];
         ctrl_q.erase   <= reg_wdata_in[ERASE_BIT];
         ctrl_q.code    <= reg_wdata_in[CODE_W-1:0];
         ctrl_q.wr      <= start_ok;
         // Hardware set wins over the value software writes
         ctrl_q.err     <= start_bad ? 1'b1 :
                           start_ok ? 1'b0 : reg_wdata_in[ERR_BIT];
      end else if (op_done) begin
         ctrl_q.wr <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         cpu_stall_out <= 1'b0;
      end else if (start_ok) begin
         cpu_stall_out <= 1'b1;
      end else if (op_done) begin
         cpu_stall_out <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Table page, pointer and holding latches
   // --------------------------------------------------------------------
   logic lat_lo_we;
   logic lat_hi_we;

   // Configuration pages take no table writes
   assign lat_lo_we = reg_wr_in && reg_addr_in == LAT_LO_OFS &&
                      !page_q[CFG_PAGE_BIT] && !ctrl_q.wr;
   assign lat_hi_we = reg_wr_in && reg_addr_in == LAT_HI_OFS &&
                      !page_q[CFG_PAGE_BIT] && !ctrl_q.wr;

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         page_q <= PAGE_RESET;
      end else if (reg_wr_in && reg_addr_in == PAGE_OFS && !ctrl_q.wr) begin
         page_q <= reg_wdata_in[7:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         ptr_q <= PTR_RESET;
      end else if (reg_wr_in && reg_addr_in == PTR_OFS && !ctrl_q.wr) begin
         ptr_q <= reg_wdata_in;
      end else if (lat_hi_we) begin
         // High byte closes a word, so step to the next one
         ptr_q <= ptr_q + PTR_STEP;
      end
   end

   fps_latch_mem u_latch (
      .sys_clk_in (sys_clk_in),
      .lo_we_in   (lat_lo_we),
      .hi_we_in   (lat_hi_we),
      .wr_idx_in  (ptr_q[LAT_IDX_W:1]),
      .wdata_in   (reg_wdata_in),
      .rd_idx_in  (word_cnt_q[LAT_IDX_W-1:0]),
      .rdata_out  (lat_rdata)
   );

   fps_op_timer u_timer (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .load_in    (tmr_load),
      .len_in     ((start_ok && dec.erase) ? ERASE_CYC : PROG_CYC),
      .done_out   (tmr_done)
   );

   // --------------------------------------------------------------------
   // Operation sequencer
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         op_state_q <= OP_IDLE;
      end else begin
         case (op_state_q)
            OP_IDLE: begin
               if (start_ok) begin
                  op_state_q <= dec.erase ? OP_WAIT : OP_LOAD;
               end
            end
            OP_LOAD: begin
               if (load_last) begin
                  op_state_q <= OP_WAIT;
               end
            end
            OP_WAIT: begin
               if (tmr_done) begin
                  op_state_q <= OP_DONE;
               end
            end
            OP_DONE: op_state_q <= OP_IDLE;
            default: op_state_q <= OP_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         op_q      <= '0;
         op_addr_q <= '0;
      end else if (start_ok) begin
         op_q      <= dec;
         op_addr_q <= start_addr;
      end
   end

   // Multi-row programs replay the one row of latches into each row
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         word_cnt_q <= '0;
         pipe_q     <= 1'b0;
         pipe_idx_q <= '0;
      end else if (start_ok) begin
         word_cnt_q <= '0;
         pipe_q     <= 1'b0;
      end else if (op_state_q == OP_LOAD && word_cnt_q != total_words) begin
         word_cnt_q <= word_cnt_q + 8'h01;
         pipe_q     <= 1'b1;
         pipe_idx_q <= word_cnt_q;
      end else begin
         pipe_q     <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Flash array requests
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         flash_req_out <= '0;
      end else begin
         flash_req_out.wr_word <= 1'b0;
         flash_req_out.erase   <= 1'b0;
         if (start_ok) begin
            flash_req_out.erase  <= dec.erase;
            flash_req_out.region <= dec.region;
            flash_req_out.rows   <= dec.rows;
            flash_req_out.addr   <= start_addr;
         end else if (pipe_q && op_state_q == OP_LOAD) begin
            flash_req_out.wr_word <= 1'b1;
            flash_req_out.addr    <= op_addr_q + {15'h0000, pipe_idx_q, 1'b0};
            flash_req_out.data    <= lat_rdata;
         end
      end
   end

   // --------------------------------------------------------------------
   // Read port
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in || !reg_rd_in) begin
         reg_rdata_out <= '0;
      end else begin
         case (reg_addr_in)
            CTRL_OFS: reg_rdata_out <= {ctrl_q.wr, ctrl_q.permit, ctrl_q.err,
                                        ctrl_q.prog_only, 5'h00, ctrl_q.erase,
                                        ctrl_q.code};
            PAGE_OFS: reg_rdata_out <= {8'h00, page_q};
            PTR_OFS:  reg_rdata_out <= ptr_q;
            default:  reg_rdata_out <= '0;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_start;
      $rose(ctrl_q.wr);
   endsequence

   sequence s_finish;
      ##[1:400] $fell(ctrl_q.wr);
   endsequence

   a_start_needs_key: assert property (
      s_start |-> $past(key_q) == KEY_ARMED)
      else $error("start without unlock");

   a_stall_follows_busy: assert property (cpu_stall_out == ctrl_q.wr)
      else $error("stall differs from busy");

   a_busy_ends: assert property (s_start |-> s_finish)
      else $error("operation never finished");

   a_busy_held: assert property (
      (op_state_q == OP_LOAD || op_state_q == OP_WAIT) |=> ctrl_q.wr)
      else $error("busy dropped early");

   a_start_needs_permit: assert property (s_start |-> ctrl_q.permit)
      else $error("start without permit");

   a_bad_start_flags: assert property (
      start_try && (key_q != KEY_ARMED || !reg_wdata_in[PERMIT_BIT])
      |=> ctrl_q.err && !ctrl_q.wr)
      else $error("bad start not flagged");

   a_unknown_code_idle: assert property (
      start_try && !start_bad && !dec.valid |=> !ctrl_q.wr)
      else $error("unknown code started");

   a_key_cancel: assert property (
      key_q == KEY_GOT55 && (reg_rd_in ||
      (reg_wr_in && !(key_wr && reg_wdata_in[7:0] == KEY_SECOND)))
      |=> key_q == KEY_IDLE)
      else $error("unlock not cancelled");

   a_ext_only_erase: assert property (
      start_ok && (dec.region == REG_ALL || dec.region == REG_BOOT)
      |-> ext_prog_mode_in)
      else $error("mode-locked erase accepted");

   a_block_aligned: assert property (
      $rose(flash_req_out.erase) && flash_req_out.region == REG_ROWS
      |-> (flash_req_out.addr & row_mask(flash_req_out.rows)) == 24'h0)
      else $error("erase block misaligned");

   a_latch_commit: assert property (
      flash_req_out.wr_word |-> $past(op_state_q) == OP_LOAD &&
      !op_q.erase)
      else $error("word written outside program");

endmodule

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
   import fps_pkg::*;
   logic                 sys_clk_in = 1'b0;
   logic                 rstn_in = 1'b0;
   logic [ADDR_W-1:0]    reg_addr_in = 4'h0;
   logic [DATA_W-1:0]    reg_wdata_in = 16'h0000;
   logic                 reg_wr_in = 1'b0;
   logic                 reg_rd_in = 1'b0;
   logic                 ext_prog_mode_in = 1'b0;
   logic [DATA_W-1:0]    reg_rdata_out;
   logic                 cpu_stall_out;
   fps_flash_req_t       flash_req_out;
   int                   n_errors = 0;
   int                   check_count = 0;
   logic [23:0]          seen_addr;
   logic [23:0]          seen_d0;
   logic [23:0]          seen_dl;
   logic [15:0] cmd [11] = '{16'hC058, 16'hC059, 16'hC05A, 16'hC04C,
      16'hC054, 16'hC018, 16'hC019, 16'hC01A, 16'hC00C, 16'hC068, 16'hC064};
   int          wrd [11] = '{0, 0, 0, 0, 0, 32, 64, 128, 0, 0, 0};

   fps_sequencer DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .ext_prog_mode_in(ext_prog_mode_in), .reg_rdata_out(reg_rdata_out),
      .cpu_stall_out(cpu_stall_out), .flash_req_out(flash_req_out));

   always #20 sys_clk_in = ~sys_clk_in;

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe: sample mid-cycle
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      @(negedge sys_clk_in);
      chk("rdata", e, reg_rdata_out);
   endtask

   // Optional unlock, start write, then track the operation to its end
   task automatic go(input logic [15:0] c, input bit unl, run, err, int ew);
      int n;
      int w;
      if (unl) begin
         wr(KEY_OFS, 16'h0055);
         wr(KEY_OFS, 16'h00AA);
      end
      wr(CTRL_OFS, c);
      // No access in the cycle after the start
      @(negedge sys_clk_in);
      chk("stall", {15'h0, run}, {15'h0, cpu_stall_out});
      chk("erase", {15'h0, run & c[6]},
          {15'h0, flash_req_out.erase});
      seen_addr = flash_req_out.addr;
      w = 0;
      for (n = 0; n < 400 && cpu_stall_out === 1'b1; n++) begin
         @(negedge sys_clk_in);
         if (flash_req_out.wr_word === 1'b1) begin
            if (w == 0) seen_addr = flash_req_out.addr;
            if (w == 0) seen_d0 = flash_req_out.data;
            seen_dl = flash_req_out.data;
            w++;
         end
      end
      if (n == 400) begin
         n_errors++;
         $display("CHECK FAILED stall_release expected 0 seen 1");
         final_report();
      end
      chk("words", 16'(ew), 16'(w));
      rd(CTRL_OFS, (c & 16'h507F) | {2'b00, err, 13'h0000});
      $display("test done ctrl %h", c);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      rd(CTRL_OFS, 16'h0000);
      rd(KEY_OFS, 16'h0000);
      rd(4'hF, 16'h0000);
      $display("test done reset");
      go(16'hC058, 0, 0, 1, 0);
      wr(KEY_OFS, 16'h00AA);
      wr(KEY_OFS, 16'h0055);
      go(16'hC058, 0, 0, 1, 0);
      wr(KEY_OFS, 16'h0055);
      wr(CTRL_OFS, 16'h4058);
      wr(KEY_OFS, 16'h00AA);
      go(16'hC058, 0, 0, 1, 0);
      wr(KEY_OFS, 16'h0055);
      wr(KEY_OFS, 16'h00AB);
      go(16'hC058, 0, 0, 1, 0);
      go(16'h8058, 1, 0, 1, 0);
      go(16'hC05F, 1, 0, 0, 0);
      // Row codes, general, config, program, no-op, serial-only codes
      for (int i = 0; i < 11; i++) begin
         go(cmd[i], 1, i < 8, 0, wrd[i]);
      end
      // Row erase: code and select first, then address, keys, start
      wr(CTRL_OFS, 16'h5059);
      rd(CTRL_OFS, 16'h5059);
      wr(PAGE_OFS, 16'h0001);
      wr(PTR_OFS, 16'h00C6);
      go(16'hC059, 1, 1, 0, 0);
      chk("erase_addr_lo", 16'h0080, seen_addr[15:0]);
      chk("erase_addr_hi", 16'h0001, {8'h00, seen_addr[23:16]});
      // One row of latch words, then program it
      wr(PTR_OFS, 16'h0040);
      for (int k = 0; k < 32; k++) begin
         wr(LAT_LO_OFS, 16'h1000 + 16'(k));
         wr(LAT_HI_OFS, 16'h00A0 + 16'(k));
      end
      rd(PTR_OFS, 16'h0080);
      wr(CTRL_OFS, 16'h4018);
      go(16'hC018, 1, 1, 0, 32);
      chk("prog_addr", 16'h0080, seen_addr[15:0]);
      chk("first_lo", 16'h1000, seen_d0[15:0]);
      chk("first_hi", 16'h00A0, {8'h00, seen_d0[23:16]});
      chk("last_lo", 16'h101F, seen_dl[15:0]);
      chk("last_hi", 16'h00BF, {8'h00, seen_dl[23:16]});
      $display("test done latches");
      @(posedge sys_clk_in);
      ext_prog_mode_in <= 1'b1;
      go(cmd[9], 1, 1, 0, 0);
      go(cmd[10], 1, 1, 0, 0);
      final_report();
   end
endmodule
